// ### hw/ptgs_pkg.sv
package ptgs_pkg;
    // register byte offsets
    localparam logic [7:0]  ADDR_CTRL      = 8'h00;
    localparam logic [7:0]  ADDR_LIMIT     = 8'h04;
    localparam logic [7:0]  ADDR_CMD       = 8'h08;
    localparam logic [7:0]  ADDR_STATUS    = 8'h0C;
    // control field positions
    localparam int          CTRL_ACT_LSB   = 0;
    localparam int          CTRL_PROG_LSB  = 2;
    localparam int          CTRL_BAL_BIT   = 5;
    localparam int          CTRL_SWON_BIT  = 6;
    localparam int          CTRL_OFS_LSB   = 8;
    localparam int          CTRL_POS_LSB   = 12;
    // limit field positions and reset values
    localparam int          LIM_MULT_LSB   = 0;
    localparam int          LIM_RUN_LSB    = 8;
    localparam int          LIM_DIFF_LSB   = 16;
    localparam logic [3:0]  MULT_RESET     = 4'h4;
    localparam logic [7:0]  RUN_RESET      = 8'h0A;
    localparam logic [2:0]  DIFF_RESET     = 3'h0;
    localparam logic [2:0]  DIFF_MAX       = 3'h6;
    // command bits (write one, self clearing)
    localparam int          CMD_ACK_BIT    = 0;
    localparam int          CMD_MAN_BIT    = 1;
    localparam int          CMD_AUTO_BIT   = 2;
    // timing
    localparam longint      CLK_HZ         = 125_000_000;
    localparam longint      TICK_S         = 1;
    localparam longint      TICK_CYCLES    = TICK_S * CLK_HZ;

    typedef enum logic [1:0] {
        ACT_OFF   = 2'b00,
        ACT_ON    = 2'b01,
        ACT_LEVEL = 2'b10,
        ACT_PULSE = 2'b11
    } ptgs_act_t;

    typedef enum logic [2:0] {
        PRG_MASTER_FOLLOWER = 3'b000,
        PRG_COORD_ONE       = 3'b001,
        PRG_COORD_TWO       = 3'b010,
        PRG_CURRENT         = 3'b011,
        PRG_CURRENT_S       = 3'b100,
        PRG_POWER_FACTOR    = 3'b101
    } ptgs_prog_t;

    typedef enum logic [1:0] {
        ROLE_SINGLE   = 2'b00,
        ROLE_MASTER   = 2'b01,
        ROLE_SLAVE    = 2'b10,
        ROLE_FOLLOWER = 2'b11
    } ptgs_role_t;

    typedef enum logic [1:0] {
        ALN_OFF   = 2'b00,
        ALN_START = 2'b01,
        ALN_LOCK  = 2'b10,
        ALN_TRACK = 2'b11
    } ptgs_aln_t;

    // what the peer network link reports, same clock domain
    typedef struct packed {
        logic       linkUp;
        logic [7:0] groupTap;
        logic       masterTapStep;
        logic       anyManual;
        logic       masterAuto;
        logic [7:0] candidates;
    } ptgs_peer_t;
endpackage : ptgs_pkg

// ### hw/parallel_tap_group_supervisor.sv
// What this block does
// R1 - activate all members, master-follower excepted
// R2 - active group realigns within 2.5 run times
// R3 - three events start a fresh group
// R4 - joiner follows toward group tap, then slave
// R5 - alignment timeout stops coupling, raises error
// R6 - timeout is n times run time, n=4
// R7 - multiplier used only in master-follower programs
// R8 - pick multiplier from run time formula; the block takes it as written to the LIMIT register, reset 4
// R9 - late joiner: error, whole group manual
// R10 - tap monitor: current programs, link up only
// R11 - tap difference too large raises error
// R12 - permitted difference 0..6, zero disables
// R13 - master-follower tolerates only fixed offset
// R14 - shared manual/auto, auto only from master
// R15 - master priority: joiner adopts master state
// R16 - manual priority: any manual, group manual
// R17 - slaves late after master step: error
// R18 - lowest group list position becomes master
// R19 - activation off, on, level, pulse toggle
// R20 - timer restarts at start, clears at equality
// R21 - error holds until deactivated or acknowledged
//
// Design decisions made here: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module parallel_tap_group_supervisor
    import ptgs_pkg::*;
#(
    parameter longint TICK_CYC = TICK_CYCLES
)(
    // clock and reset
    input  wire  logic        core_clk,
    input  wire  logic        rst_n,
    // ahb-lite slave
    input  wire  logic        hsel,
    input  wire  logic [31:0] haddr,
    input  wire  logic [1:0]  htrans,
    input  wire  logic        hwrite,
    input  wire  logic [2:0]  hsize,
    input  wire  logic [31:0] hwdata,
    input  wire  logic        hready,
    output logic       [31:0] hrdata,
    output logic              hreadyout,
    output logic              hresp,
    // local regulator
    input  wire  logic        activationPin,
    input  wire  logic [7:0]  localTap,
    input  wire  ptgs_peer_t  peer,
    // group side
    output logic              parallelError,
    output logic              autoMode,
    output logic              groupManualReq,
    output logic              tapRaise,
    output logic              tapLower,
    output logic [1:0]        role
);
    typedef struct packed {
        logic [31:0] hrdata;
        logic        hreadyout;
        logic        wrPend;
        logic [7:0]  wrAddr;
        ptgs_act_t   actMode;
        ptgs_prog_t  prog;
        logic        balManual;
        logic        swOn;
        logic [3:0]  tapOffset;
        logic [2:0]  ownPos;
        logic [3:0]  mult;
        logic [7:0]  maxRun;
        logic [2:0]  tapDiffMax;
        logic [2:0]  cmd;
        logic        actSync1;
        logic        actSync2;
        logic        actPrev;
        logic        pulseOn;
        logic [26:0] tickCnt;
        logic        tick;
        logic        coupled;
        logic        isMaster;
        logic [2:0]  masterPos;
        logic        auto;
        logic        parallel_error;
        ptgs_aln_t   aln;
        logic [11:0] timer;
        ptgs_role_t  role;
        logic        tapRaise;
        logic        tapLower;
        logic        groupManual;
    } ptgs_state_t;

    ptgs_state_t s;
    ptgs_state_t next_s;

    logic        mfMode;
    logic        curMode;
    logic        parOn;
    logic        pulseEdge;
    logic [2:0]  elected;
    logic        electedValid;
    logic [7:0]  target;
    logic [7:0]  tapDiff;
    logic        equal;
    logic        joinEvt;
    logic        masterChg;
    logic        startEvt;
    logic        stay;
    logic [11:0] limitStart;
    logic [11:0] limitTrack;
    logic [12:0] run5;
    logic        errSet;

    function automatic logic [31:0] readReg(input logic [7:0] a, input ptgs_state_t st);
        logic [31:0] r;
        r = '0;
        case (a)
            ADDR_CTRL:
            begin
                r[CTRL_ACT_LSB +: 2]  = st.actMode;
                r[CTRL_PROG_LSB +: 3] = st.prog;
                r[CTRL_BAL_BIT]       = st.balManual;
                r[CTRL_SWON_BIT]      = st.swOn;
                r[CTRL_OFS_LSB +: 4]  = st.tapOffset;
                r[CTRL_POS_LSB +: 3]  = st.ownPos;
            end
            ADDR_LIMIT:
            begin
                r[LIM_MULT_LSB +: 4] = st.mult;
                r[LIM_RUN_LSB +: 8]  = st.maxRun;
                r[LIM_DIFF_LSB +: 3] = st.tapDiffMax;
            end
            ADDR_STATUS:
                r = {1'b0, st.timer, st.groupManual, st.tapLower, st.tapRaise, st.aln, st.role,
                     st.parallel_error, st.auto, st.isMaster, st.coupled, st.pulseOn, 4'h0, st.masterPos};
            default:
                r = '0;
        endcase
        return r;
    endfunction : readReg

    always_comb
    begin
        mfMode  = (s.prog == PRG_MASTER_FOLLOWER) || (s.prog == PRG_COORD_ONE) || (s.prog == PRG_COORD_TWO);
        curMode = (s.prog == PRG_CURRENT) || (s.prog == PRG_CURRENT_S) || (s.prog == PRG_POWER_FACTOR);
        elected      = 3'h0;
        electedValid = 1'b0;
        for (int i = 7; i >= 0; i--)
        begin
            if (peer.candidates[i])
            begin
                elected      = 3'(i); // R18
                electedValid = 1'b1;
            end
        end
        target  = localTap + {{4{s.tapOffset[3]}}, s.tapOffset}; // R13
        tapDiff = (target >= peer.groupTap) ? target - peer.groupTap : peer.groupTap - target;
        equal   = (tapDiff == 8'h00);
        run5    = {5'h00, s.maxRun} + {3'h0, s.maxRun, 2'b00};
        limitStart = 12'({8'h00, s.mult} * {4'h0, s.maxRun}); // R6
        limitTrack = run5[12:1]; // R2
        pulseEdge  = s.actSync2 && !s.actPrev;
        case (s.actMode) // R19
            ACT_OFF:   parOn = 1'b0;
            ACT_ON:    parOn = s.swOn;
            ACT_LEVEL: parOn = s.actSync2;
            ACT_PULSE: parOn = s.pulseOn;
            default:   parOn = 1'b0;
        endcase
    end

    always_comb
    begin
        next_s           = s;
        next_s.cmd       = 3'h0;
        next_s.hreadyout = 1'b1;
        errSet           = 1'b0;
        // pin synchroniser
        next_s.actSync1 = activationPin;
        next_s.actSync2 = s.actSync1;
        next_s.actPrev  = s.actSync2;
        // free-running seconds tick
        next_s.tick = 1'b0;
        if (s.tickCnt == 27'(TICK_CYC - 1))
        begin
            next_s.tickCnt = '0;
            next_s.tick    = 1'b1;
        end
        else
            next_s.tickCnt = s.tickCnt + 27'h000_0001;
        // bus data phase
        if (s.wrPend)
        begin
            next_s.wrPend = 1'b0;
            case (s.wrAddr)
                ADDR_CTRL:
                begin
                    next_s.actMode   = ptgs_act_t'(hwdata[CTRL_ACT_LSB +: 2]);
                    next_s.prog      = ptgs_prog_t'(hwdata[CTRL_PROG_LSB +: 3]);
                    next_s.balManual = hwdata[CTRL_BAL_BIT];
                    next_s.swOn      = hwdata[CTRL_SWON_BIT];
                    next_s.tapOffset = hwdata[CTRL_OFS_LSB +: 4];
                    next_s.ownPos    = hwdata[CTRL_POS_LSB +: 3];
                end
                ADDR_LIMIT:
                begin
                    next_s.mult       = hwdata[LIM_MULT_LSB +: 4];
                    next_s.maxRun     = hwdata[LIM_RUN_LSB +: 8];
                    next_s.tapDiffMax = (hwdata[LIM_DIFF_LSB +: 3] > DIFF_MAX) ? DIFF_MAX
                                                                                : hwdata[LIM_DIFF_LSB +: 3]; // R12
                end
                ADDR_CMD:
                    next_s.cmd = hwdata[2:0];
                default:
                    next_s.cmd = 3'h0;
            endcase
        end
        // bus address phase, zero wait states
        if (hsel && htrans[1] && hready)
        begin
            next_s.wrPend = hwrite;
            next_s.wrAddr = haddr[7:0];
            if (!hwrite)
                next_s.hrdata = readReg(haddr[7:0], s);
        end
        // activation
        if (s.actMode == ACT_PULSE && pulseEdge)
            next_s.pulseOn = !s.pulseOn; // R19
        else if (s.actMode != ACT_PULSE)
            next_s.pulseOn = 1'b0;
        next_s.coupled   = parOn && !s.parallel_error; // R5
        next_s.masterPos = elected;
        next_s.isMaster  = next_s.coupled && electedValid && (elected == s.ownPos); // R18
        joinEvt   = next_s.coupled && !s.coupled;
        masterChg = next_s.coupled && s.coupled && (elected != s.masterPos);
        // manual/automatic balance
        if (s.cmd[CMD_MAN_BIT])
            next_s.auto = 1'b0;
        else if (s.cmd[CMD_AUTO_BIT] && (!(mfMode && s.coupled) || s.isMaster))
            next_s.auto = 1'b1; // R14
        if (mfMode && joinEvt)
        begin
            if (s.balManual && (peer.anyManual || !s.auto))
                next_s.auto = 1'b0; // R16
            else if (!s.balManual && !next_s.isMaster)
                next_s.auto = peer.masterAuto; // R15
        end
        else if (mfMode && s.coupled && peer.anyManual)
            next_s.auto = 1'b0; // R14
        // fresh group start
        startEvt = mfMode && next_s.coupled && next_s.auto
                   && ((joinEvt && s.auto) || masterChg || !s.auto); // R3
        stay = mfMode && next_s.coupled && next_s.auto;
        // alignment supervision, master-follower programs only
        if (!stay)
        begin
            next_s.aln   = ALN_OFF; // R7
            next_s.timer = '0;
        end
        else if (startEvt)
        begin
            next_s.aln   = ALN_START;
            next_s.timer = '0; // R20
        end
        else
        begin
            case (s.aln)
                ALN_OFF:
                begin
                    next_s.aln   = ALN_START;
                    next_s.timer = '0;
                end
                ALN_START, ALN_TRACK:
                begin
                    if (equal)
                    begin
                        next_s.aln   = ALN_LOCK;
                        next_s.timer = '0; // R20
                    end
                    else if (s.aln == ALN_TRACK && peer.masterTapStep)
                        next_s.timer = '0;
                    else if (s.tick)
                    begin
                        next_s.timer = s.timer + 12'h001;
                        if (s.aln == ALN_START && next_s.timer >= limitStart)
                            errSet = 1'b1; // R5 R9
                        if (s.aln == ALN_TRACK && next_s.timer >= limitTrack)
                            errSet = 1'b1; // R17
                    end
                end
                ALN_LOCK:
                begin
                    if (peer.masterTapStep)
                    begin
                        next_s.aln   = ALN_TRACK; // R2
                        next_s.timer = '0;
                    end
                end
                default:
                    next_s.aln = ALN_OFF;
            endcase
        end
        // tap difference supervision
        if (curMode && peer.linkUp && s.coupled && s.tapDiffMax != DIFF_RESET
            && tapDiff > {5'h00, s.tapDiffMax}) // R10 R12
            errSet = 1'b1; // R11
        // sticky error, a new set wins over the clear
        next_s.parallel_error = errSet || (s.parallel_error && !s.cmd[CMD_ACK_BIT] && parOn); // R21
        if (next_s.parallel_error)
            next_s.auto = 1'b0; // R5 R9 R11
        // role and stepping
        if (!next_s.coupled)
            next_s.role = ROLE_SINGLE;
        else if (next_s.isMaster)
            next_s.role = ROLE_MASTER;
        else if (next_s.aln == ALN_START && !equal)
            next_s.role = ROLE_FOLLOWER; // R4
        else
            next_s.role = ROLE_SLAVE; // R4
        next_s.tapRaise    = (next_s.role == ROLE_FOLLOWER) && (target < peer.groupTap); // R4
        next_s.tapLower    = (next_s.role == ROLE_FOLLOWER) && (target > peer.groupTap); // R4
        next_s.groupManual = next_s.parallel_error || (mfMode && next_s.coupled && !next_s.auto); // R9 R14
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s            <= '0;
            s.hreadyout  <= 1'b1;
            s.mult       <= MULT_RESET; // R6
            s.maxRun     <= RUN_RESET;
            s.tapDiffMax <= DIFF_RESET;
            s.aln        <= ALN_OFF;
            s.role       <= ROLE_SINGLE;
        end
        else
            s <= next_s;
    end

    assign hrdata         = s.hrdata;
    assign hreadyout      = s.hreadyout;
    assign hresp          = 1'b0;
    assign parallelError  = s.parallel_error;
    assign autoMode       = s.auto;
    assign groupManualReq = s.groupManual;
    assign tapRaise       = s.tapRaise;
    assign tapLower       = s.tapLower;
    assign role           = s.role;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence seqStart;
        startEvt ##1 (s.aln == ALN_START && s.timer == 12'h000);
    endsequence
    sequence seqHeld;
        (s.parallel_error && !s.cmd[CMD_ACK_BIT] && parOn) ##1 s.parallel_error;
    endsequence

    chk_start_arms_timer: assert property (startEvt |-> seqStart) else $error("start did not arm timer"); // R3
    chk_error_sticky: assert property (s.parallel_error && !s.cmd[CMD_ACK_BIT] && parOn |-> seqHeld)
        else $error("error dropped"); // R21
    chk_error_manual: assert property (s.parallel_error |-> !s.auto) else $error("error left auto"); // R5
    chk_start_limit: assert property (s.aln == ALN_START && !s.parallel_error |-> s.timer <= limitStart)
        else $error("start timer overran"); // R6
    chk_track_limit: assert property (s.aln == ALN_TRACK && !s.parallel_error |-> s.timer <= limitTrack)
        else $error("track timer overran"); // R2
    chk_diff_range: assert property (s.tapDiffMax <= DIFF_MAX) else $error("difference out of range"); // R12
    chk_follower_steps: assert property (s.tapRaise || s.tapLower |-> s.role == ROLE_FOLLOWER)
        else $error("step outside follower"); // R4
    chk_equal_locks: assert property (s.aln == ALN_START && equal && stay && !startEvt |=> s.aln == ALN_LOCK)
        else $error("equality not locked"); // R20
    chk_auto_master: assert property (s.cmd[CMD_AUTO_BIT] && mfMode && s.coupled && !s.isMaster && !s.auto
        && !joinEvt |=> !s.auto) else $error("auto taken at non-master"); // R14
    chk_pulse_toggle: assert property (s.actMode == ACT_PULSE && pulseEdge |=> s.pulseOn != $past(s.pulseOn))
        else $error("pulse did not toggle"); // R19
endmodule : parallel_tap_group_supervisor
`default_nettype wire

// ### verification/ptgs_peer_model.sv
`timescale 1ns/1ns
`default_nettype none
module ptgs_peer_model
    import ptgs_pkg::*;
(
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // scenario controls
    input  wire logic       linkCmd,
    input  wire logic       loadCmd,
    input  wire logic [7:0] tapCmd,
    input  wire logic       stepCmd,
    input  wire logic       manualCmd,
    input  wire logic       masterAutoCmd,
    input  wire logic [7:0] candCmd,
    // link towards the supervisor
    output var  ptgs_peer_t peer
);
    logic [7:0] tapReg;
    logic       stepReg;

    // a master tap change moves the group tap and gives a one-cycle step pulse
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tapReg  <= 8'h00;
            stepReg <= 1'b0;
        end
        else
        begin
            stepReg <= stepCmd;
            if (stepCmd)
                tapReg <= tapReg + 8'h01;
            else if (loadCmd)
                tapReg <= tapCmd;
        end
    end

    // a dead link carries no valid tap: show the inverse of the held value
    always_comb
    begin
        peer.linkUp        = linkCmd;
        peer.groupTap      = linkCmd ? tapReg : ~tapReg;
        peer.masterTapStep = stepReg & linkCmd;
        peer.anyManual     = manualCmd;
        peer.masterAuto    = masterAutoCmd;
        // the group reports who may be master, first-activated one included
        peer.candidates    = candCmd;
    end
endmodule : ptgs_peer_model
`default_nettype wire

// ### verification/parallel_tap_group_supervisor_tb.sv
`timescale 1ns/1ns
`default_nettype none
module parallel_tap_group_supervisor_tb
    import ptgs_pkg::*;
;
    // multiplier 4, run time 2 s: alignment limit 8 s, tracking limit 5 s
    localparam logic [31:0] LIM_STD = 32'h0000_0204;
    localparam logic [31:0] CTRL_MF = 32'h0000_1041;
    logic        core_clk = 1'b0;
    logic        rst_n, hsel, hwrite, activationPin, tcEn, hreadyout, hresp;
    logic        parallelError, autoMode, groupManualReq, tapRaise, tapLower;
    logic        linkCmd, loadCmd, stepCmd, manualCmd, masterAutoCmd;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans, role;
    logic [7:0]  localTap, ltStart, tapCmd, candCmd;
    ptgs_peer_t  peer;
    int          error_cnt, cmp_count, tcCnt, a;

    always #4 core_clk = ~core_clk;

    parallel_tap_group_supervisor #(.TICK_CYC(10)) u_parallel_tap_group_supervisor (
        .core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .activationPin(activationPin), .localTap(localTap),
        .peer(peer), .parallelError(parallelError), .autoMode(autoMode),
        .groupManualReq(groupManualReq), .tapRaise(tapRaise), .tapLower(tapLower), .role(role));

    ptgs_peer_model u_ptgs_peer_model (
        .core_clk(core_clk), .rst_n(rst_n), .linkCmd(linkCmd), .loadCmd(loadCmd), .tapCmd(tapCmd),
        .stepCmd(stepCmd), .manualCmd(manualCmd), .masterAutoCmd(masterAutoCmd), .candCmd(candCmd),
        .peer(peer));

    // local tap changer: one step every 7 cycles while asked and enabled
    always @(posedge core_clk)
    begin
        tcCnt <= (tcEn && (tapRaise || tapLower) && tcCnt != 6) ? tcCnt + 1 : 0;
        if (!rst_n)
            localTap <= ltStart;
        else if (tcCnt == 6)
            localTap <= tapRaise ? localTap + 8'h01 : localTap - 8'h01;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] d, output logic [31:0] q);
        @(posedge core_clk);
        hsel   <= 1'b1;
        haddr  <= {24'h00_0000, ad};
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        q = hrdata;
    endtask : bus

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : cyc

    function automatic logic [1:0] pick(input int sel);
        case (sel)
            0:       return {1'b0, parallelError};
            1:       return role;
            default: return {1'b0, autoMode};
        endcase
    endfunction : pick

    task automatic wait_for(input int sel, input logic [1:0] v, input int maxc);
        int i;
        #1;
        for (i = 0; i < maxc && pick(sel) !== v; i++)
            cyc(1);
        chk(pick(sel), v);
    endtask : wait_for

    task automatic restart(input logic [7:0] lt, input logic [7:0] gt, input logic [7:0] cand,
                           input logic tc, input logic man, input logic link, input logic [31:0] lim);
        @(posedge core_clk);
        rst_n         <= 1'b0;
        ltStart       <= lt;
        tapCmd        <= gt;
        candCmd       <= cand;
        tcEn          <= tc;
        manualCmd     <= man;
        linkCmd       <= link;
        masterAutoCmd <= 1'b1;
        loadCmd       <= 1'b1;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        if (lim !== 32'h0000_0000)
            bus(1'b1, ADDR_LIMIT, lim, rd);
        loadCmd <= 1'b0;
    endtask : restart

    task automatic end_sim;
        if (error_cnt == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_sim

    initial
    begin
        repeat (20000) @(posedge core_clk);
        error_cnt++;
        $display("wrong value at %0t: run did not finish", $time);
        end_sim;
    end

    initial
    begin
        {rst_n, hsel, hwrite, activationPin, tcEn, stepCmd, loadCmd} = '0;
        {linkCmd, manualCmd, masterAutoCmd, haddr, hwdata, htrans, ltStart, tapCmd, candCmd} = '0;
        {error_cnt, cmp_count} = '0;
        // register reset values, clamping, activation modes
        restart(8'h08, 8'h08, 8'h01, 1'b0, 1'b0, 1'b1, 32'h0000_0000);
        bus(1'b0, ADDR_LIMIT, 0, rd);
        chk(rd, 32'h0000_0A04);
        bus(1'b0, 8'h10, 0, rd);
        chk(rd, 32'h0000_0000);
        bus(1'b1, ADDR_LIMIT, 32'h0007_0204, rd);
        bus(1'b0, ADDR_LIMIT, 0, rd);
        chk(rd, 32'h0006_0204);
        @(posedge core_clk);
        activationPin <= 1'b1;
        for (a = 0; a < 3; a++)
        begin
            bus(1'b1, ADDR_CTRL, 32'h0000_104C | a, rd);
            cyc(5);
            bus(1'b0, ADDR_STATUS, 0, rd);
            chk(rd[8], a != 0);
        end
        @(posedge core_clk);
        activationPin <= 1'b0;
        cyc(5);
        bus(1'b0, ADDR_STATUS, 0, rd);
        chk(rd[8], 0);
        bus(1'b1, ADDR_CTRL, 32'h0000_104F, rd);
        for (a = 0; a < 2; a++)
        begin
            @(posedge core_clk);
            activationPin <= 1'b1;
            repeat (3) @(posedge core_clk);
            activationPin <= 1'b0;
            cyc(5);
            bus(1'b0, ADDR_STATUS, 0, rd);
            chk(rd[8], a == 0);
        end
        // joiner follows to the group tap, then a master step goes unanswered
        restart(8'h05, 8'h08, 8'h01, 1'b1, 1'b0, 1'b1, LIM_STD);
        bus(1'b1, ADDR_CMD, 32'h0000_0004, rd);
        bus(1'b1, ADDR_CTRL, CTRL_MF, rd);
        wait_for(1, ROLE_FOLLOWER, 10);
        chk(tapRaise, 1);
        wait_for(1, ROLE_SLAVE, 60);
        chk({tapRaise, localTap}, 9'h008);
        bus(1'b0, ADDR_STATUS, 0, rd);
        chk(rd[30:19], 0);
        @(posedge core_clk);
        tcEn    <= 1'b0;
        stepCmd <= 1'b1;
        @(posedge core_clk);
        stepCmd <= 1'b0;
        cyc(32);
        chk(parallelError, 0);
        wait_for(0, 2'h1, 30);
        chk({groupManualReq, autoMode}, 2'h2);
        cyc(20);
        chk(parallelError, 1);
        bus(1'b1, ADDR_CMD, 32'h0000_0001, rd);
        wait_for(0, 2'h0, 3);
        // joiner never moves: alignment timeout after n run times
        restart(8'h05, 8'h08, 8'h01, 1'b0, 1'b0, 1'b1, LIM_STD);
        bus(1'b1, ADDR_CMD, 32'h0000_0004, rd);
        bus(1'b1, ADDR_CTRL, CTRL_MF, rd);
        cyc(60);
        chk(parallelError, 0);
        wait_for(0, 2'h1, 40);
        chk({groupManualReq, autoMode}, 2'h2);
        bus(1'b0, ADDR_STATUS, 0, rd);
        chk(rd[8], 0);
        bus(1'b1, ADDR_CTRL, 32'h0000_0000, rd);
        wait_for(0, 2'h0, 3);
        // offset join, shared manual state, master election
        restart(8'h07, 8'h08, 8'h01, 1'b0, 1'b0, 1'b1, LIM_STD);
        bus(1'b1, ADDR_CMD, 32'h0000_0004, rd);
        bus(1'b1, ADDR_CTRL, CTRL_MF | 32'h0000_0100, rd);
        wait_for(1, ROLE_SLAVE, 10);
        chk(tapRaise, 0);
        @(posedge core_clk);
        manualCmd <= 1'b1;
        wait_for(2, 2'h0, 5);
        @(posedge core_clk);
        manualCmd <= 1'b0;
        bus(1'b1, ADDR_CMD, 32'h0000_0004, rd);
        cyc(3);
        chk(autoMode, 0);
        @(posedge core_clk);
        candCmd <= 8'h06;
        wait_for(1, ROLE_MASTER, 10);
        bus(1'b0, ADDR_STATUS, 0, rd);
        chk(rd[2:0], 3'h1);
        bus(1'b1, ADDR_CMD, 32'h0000_0004, rd);
        wait_for(2, 2'h1, 3);
        // manual/automatic balance at join: master priority, then manual priority
        for (a = 0; a < 2; a++)
        begin
            restart(8'h08, 8'h08, 8'h01, 1'b0, a[0], 1'b1, LIM_STD);
            if (a == 1)
                bus(1'b1, ADDR_CMD, 32'h0000_0004, rd);
            bus(1'b1, ADDR_CTRL, CTRL_MF | (a * 32'h0000_0020), rd);
            wait_for(2, (a == 0) ? 2'h1 : 2'h0, 10);
        end
        // tap-difference monitor in the current program
        restart(8'h05, 8'h08, 8'h01, 1'b0, 1'b0, 1'b0, 32'h0002_0204);
        bus(1'b1, ADDR_CTRL, 32'h0000_104D, rd);
        cyc(30);
        chk(parallelError, 0);
        @(posedge core_clk);
        linkCmd <= 1'b1;
        wait_for(0, 2'h1, 5);
        bus(1'b1, ADDR_LIMIT, 32'h0003_0204, rd);
        bus(1'b1, ADDR_CMD, 32'h0000_0001, rd);
        cyc(20);
        chk(parallelError, 0);
        bus(1'b1, ADDR_LIMIT, LIM_STD, rd);
        cyc(100);
        chk(parallelError, 0);
        end_sim;
    end
endmodule : parallel_tap_group_supervisor_tb
`default_nettype wire
